// >>> verilog/ims_master_seq.sv
// Two-wire bus master sequencer with AXI4-Lite register access
// Summary of operation
// - Data byte sent and NACK received reports 0x30; reload, restart or stop allowed.
// - Start and stop requested together: STOP, then START, stop request self-clears.
// - Arbitration lost in write address or data reports 0x38 and releases bus.
// - After 0x38, flag clear with start request waits for free bus, then START.
// - Master mode follows START; address read/write bit picks receive or transmit.
// - START emitted once bus free, then flag set with status 0x08.
// - After read address and acknowledge, flag set with 0x38, 0x40 or 0x48.
// - Received byte appears in data register when the flag is set.
// - Control pattern 1x01x10x makes the device emit a STOP.
// - Repeated START reports 0x10 and keeps bus ownership.
// - After 0x10 the loaded address is sent; its bit selects the mode.
// - Arbitration lost in read address or NACK bit reports 0x38.
// - On 0x40, flag clear receives a byte, ACK if ack enable set.
// - On 0x48 only repeated START, STOP, or STOP then START accepted.
// - On 0x50 the next byte is received, ACK or NACK per ack enable.
// - On 0x58 only repeated START, STOP, or STOP then START performed.
// - Completing a STOP clears the stop request without software.
// - Start without stop on flag clear in allowed state gives repeated START.
`timescale 1ns/1ps
`include "ims_map.svh"

module ims_master_seq (
  input  wire logic                   CLOCK,          // System clock, 40 MHz
  input  wire logic                   SYS_RST,        // Synchronous reset, active high
  input  wire logic [`IMS_ADDR_W-1:0] S_AXI_AWADDR,   // Write address
  input  wire logic                   S_AXI_AWVALID,  // Write address valid
  output logic                        S_AXI_AWREADY,  // Write address ready
  input  wire logic [31:0]            S_AXI_WDATA,    // Write data
  input  wire logic [3:0]             S_AXI_WSTRB,    // Write byte strobes
  input  wire logic                   S_AXI_WVALID,   // Write data valid
  output logic                        S_AXI_WREADY,   // Write data ready
  output logic [1:0]                  S_AXI_BRESP,    // Write response
  output logic                        S_AXI_BVALID,   // Write response valid
  input  wire logic                   S_AXI_BREADY,   // Write response ready
  input  wire logic [`IMS_ADDR_W-1:0] S_AXI_ARADDR,   // Read address
  input  wire logic                   S_AXI_ARVALID,  // Read address valid
  output logic                        S_AXI_ARREADY,  // Read address ready
  output logic [31:0]                 S_AXI_RDATA,    // Read data
  output logic [1:0]                  S_AXI_RRESP,    // Read response
  output logic                        S_AXI_RVALID,   // Read data valid
  input  wire logic                   S_AXI_RREADY,   // Read data ready
  input  wire logic                   SCL_IN,         // Bus clock level seen on the wire
  output logic                        SCL_OUT,        // Bus clock drive level, always low
  output logic                        SCL_OE,         // Bus clock pulled low when high
  input  wire logic                   SDA_IN,         // Bus data level seen on the wire
  output logic                        SDA_OUT,        // Bus data drive level, always low
  output logic                        SDA_OE          // Bus data pulled low when high
);

  localparam logic [7:0] QTR_LAST = 8'(`IMS_QTR_CYC - 1);

  ims_pkg::ims_top_s r_reg;
  ims_pkg::ims_top_s r_next;
  logic              scl_s;
  logic              sda_s;
  logic              adv;
  logic              arb_lost;
  logic              finish;
  logic              data_wr_nf;
  logic              clear_go;

  // =====================================================================
  // Pin synchronisers
  ims_sync u_scl_sync (
    .clk (CLOCK),
    .rst (SYS_RST),
    .d   (SCL_IN),
    .q   (scl_s)
  );

  ims_sync u_sda_sync (
    .clk (CLOCK),
    .rst (SYS_RST),
    .d   (SDA_IN),
    .q   (sda_s)
  );

  // =====================================================================
  // Sequence launchers
  function automatic ims_pkg::ims_top_s go_byte(input ims_pkg::ims_top_s s, input logic [8:0] t,
                                                 input logic [8:0] c, input ims_pkg::ims_kind_e k);
    s.st      = ims_pkg::S_BIT;
    s.ph      = 2'h0;
    s.cnt     = 8'h00;
    s.bitn    = 4'h0;
    s.tx      = t;
    s.chk     = c;
    s.kind    = k;
    s.rx      = 9'h000;
    s.sda_low = !t[8];
    return s;
  endfunction : go_byte

  function automatic ims_pkg::ims_top_s go_start(input ims_pkg::ims_top_s s, input logic rp);
    s.st      = ims_pkg::S_START;
    s.ph      = 2'h0;
    s.cnt     = 8'h00;
    s.rep     = rp;
    s.sda_low = 1'b0;
    return s;
  endfunction : go_start

  function automatic ims_pkg::ims_top_s go_stop(input ims_pkg::ims_top_s s, input logic then_start);
    s.st      = ims_pkg::S_STOP;
    s.ph      = 2'h0;
    s.cnt     = 8'h00;
    s.sts     = then_start;
    s.sda_low = 1'b1;
    return s;
  endfunction : go_stop

  // =====================================================================
  // Next state
  always_comb begin
    r_next     = r_reg;
    adv        = 1'b0;
    arb_lost   = 1'b0;
    finish     = 1'b0;
    data_wr_nf = 1'b0;
    clear_go   = 1'b0;

    // Bus free tracking from START and STOP seen on the wire
    r_next.scl_q = scl_s;
    r_next.sda_q = sda_s;
    if (scl_s && r_reg.scl_q && r_reg.sda_q && !sda_s) begin
      r_next.busy = 1'b1;
    end else if (scl_s && r_reg.scl_q && !r_reg.sda_q && sda_s) begin
      r_next.busy = 1'b0;
    end

    // Write channels, address and data in either order
    if (S_AXI_AWVALID && r_reg.aw_rdy) begin
      r_next.aw_ok   = 1'b1;
      r_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && r_reg.w_rdy) begin
      r_next.w_ok   = 1'b1;
      r_next.w_data = S_AXI_WDATA[7:0];
      r_next.w_strb = S_AXI_WSTRB[0];
    end
    if (S_AXI_BREADY && r_reg.bvalid) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid) begin
      r_next.aw_ok  = 1'b0;
      r_next.w_ok   = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = `IMS_RESP_OK;
      case (r_reg.aw_addr)
        `IMS_OFS_CTRL: begin
          if (r_reg.w_strb) begin
            r_next.ea  = r_reg.w_data[`IMS_B_ACK];
            r_next.start_request_bit = r_reg.w_data[`IMS_B_STA];
            r_next.stop_request_bit = r_reg.w_data[`IMS_B_STO];
            r_next.en  = r_reg.w_data[`IMS_B_EN];
            if (r_reg.w_data[`IMS_B_FLAG]) begin
              r_next.flag = 1'b0;
              clear_go    = 1'b1;
            end
          end
        end
        `IMS_OFS_STATUS: begin
        end
        `IMS_OFS_DATA: begin
          if (r_reg.w_strb) begin
            if (r_reg.flag) begin
              r_next.data = r_reg.w_data;
              r_next.wc   = 1'b0;
            end else begin
              r_next.wc  = 1'b1;
              data_wr_nf = 1'b1;
            end
          end
        end
        default: r_next.bresp = `IMS_RESP_ERR;
      endcase
    end
    r_next.aw_rdy = !r_next.aw_ok;
    r_next.w_rdy  = !r_next.w_ok;

    // Read channel
    if (S_AXI_RREADY && r_reg.rvalid) begin
      r_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && r_reg.ar_rdy) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = `IMS_RESP_OK;
      case (S_AXI_ARADDR)
        `IMS_OFS_CTRL:   r_next.rdata = {r_reg.flag, r_reg.ea, r_reg.start_request_bit, r_reg.stop_request_bit, r_reg.wc, r_reg.en, 2'h0};
        `IMS_OFS_STATUS: r_next.rdata = r_reg.status;
        `IMS_OFS_DATA:   r_next.rdata = r_reg.data;
        default: begin
          r_next.rdata = 8'h00;
          r_next.rresp = `IMS_RESP_ERR;
        end
      endcase
    end
    r_next.ar_rdy = !r_next.rvalid;

    // Flag clear picks the next bus action from the current status
    if (clear_go && r_next.en && (r_reg.st == ims_pkg::S_HOLD || r_reg.st == ims_pkg::S_IDLE)) begin
      case (r_reg.status)
        `IMS_S_START, `IMS_S_REP: begin
          r_next.rd = r_reg.data[0];
          r_next    = go_byte(r_next, {r_reg.data, 1'b1}, 9'h1fe, ims_pkg::K_ADDR);
        end
        `IMS_S_AW_ACK, `IMS_S_AW_NACK, `IMS_S_TX_ACK, `IMS_S_TX_NACK: begin
          if (r_next.stop_request_bit) begin
            r_next = go_stop(r_next, r_next.start_request_bit);
          end else if (r_next.start_request_bit) begin
            r_next = go_start(r_next, 1'b1);
          end else begin
            r_next = go_byte(r_next, {r_reg.data, 1'b1}, 9'h1fe, ims_pkg::K_TX);
          end
        end
        `IMS_S_AR_ACK, `IMS_S_RX_ACK: begin
          r_next = go_byte(r_next, {8'hff, !r_next.ea}, 9'h001, ims_pkg::K_RX);
        end
        `IMS_S_AR_NACK, `IMS_S_RX_NACK: begin
          if (r_next.stop_request_bit) begin
            r_next = go_stop(r_next, r_next.start_request_bit);
          end else if (r_next.start_request_bit) begin
            r_next = go_start(r_next, 1'b1);
          end else begin
            r_next.flag = 1'b1;
          end
        end
        default: begin
          if (r_next.start_request_bit) begin
            r_next.st = ims_pkg::S_WAIT_FREE;
          end
        end
      endcase
    end

    // Quarter-bit timing, held while a slave stretches the clock
    if (r_reg.st == ims_pkg::S_START || r_reg.st == ims_pkg::S_BIT || r_reg.st == ims_pkg::S_STOP) begin
      if (!r_reg.scl_low && !scl_s) begin
        r_next.cnt = r_reg.cnt;
      end else if (r_reg.cnt == QTR_LAST) begin
        r_next.cnt = 8'h00;
        adv        = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 8'h01;
      end
    end

    if (r_reg.st == ims_pkg::S_WAIT_FREE && !r_reg.busy && scl_s && sda_s) begin
      r_next = go_start(r_next, 1'b0);
    end

    if (adv) begin
      r_next.ph = r_reg.ph + 2'h1;
      case (r_reg.st)
        ims_pkg::S_START: begin
          case (r_reg.ph)
            2'h0: r_next.scl_low = 1'b0;
            2'h1: r_next.sda_low = 1'b1;
            2'h2: r_next.scl_low = 1'b1;
            default: begin
              r_next.flag   = 1'b1;
              r_next.owner  = 1'b1;
              r_next.st     = ims_pkg::S_HOLD;
              r_next.status = r_reg.rep ? `IMS_S_REP : `IMS_S_START;
            end
          endcase
        end
        ims_pkg::S_BIT: begin
          case (r_reg.ph)
            2'h0: r_next.scl_low = 1'b0;
            2'h1: begin
              r_next.rx = {r_reg.rx[7:0], sda_s};
              arb_lost  = r_reg.chk[8] && r_reg.tx[8] && !sda_s;
            end
            2'h2: r_next.scl_low = 1'b1;
            default: begin
              if (r_reg.bitn == 4'h8) begin
                finish = 1'b1;
              end else begin
                r_next.tx      = {r_reg.tx[7:0], 1'b1};
                r_next.chk     = {r_reg.chk[7:0], 1'b0};
                r_next.bitn    = r_reg.bitn + 4'h1;
                r_next.sda_low = !r_reg.tx[7];
              end
            end
          endcase
        end
        ims_pkg::S_STOP: begin
          case (r_reg.ph)
            2'h0: r_next.scl_low = 1'b0;
            2'h1: r_next.sda_low = 1'b0;
            2'h2: r_next.scl_low = 1'b0;
            default: begin
              r_next.stop_request_bit    = 1'b0;
              r_next.owner  = 1'b0;
              r_next.status = `IMS_S_IDLE;
              r_next.st     = r_reg.sts ? ims_pkg::S_WAIT_FREE : ims_pkg::S_IDLE;
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    if (arb_lost) begin
      r_next.st      = ims_pkg::S_IDLE;
      r_next.scl_low = 1'b0;
      r_next.sda_low = 1'b0;
      r_next.owner   = 1'b0;
      r_next.flag    = 1'b1;
      r_next.status  = `IMS_S_ARB;
    end

    if (finish) begin
      r_next.flag    = 1'b1;
      r_next.sda_low = 1'b0;
      r_next.st      = ims_pkg::S_HOLD;
      case (r_reg.kind)
        ims_pkg::K_ADDR: begin
          if (r_reg.rd) begin
            r_next.status = r_reg.rx[0] ? `IMS_S_AR_NACK : `IMS_S_AR_ACK;
          end else begin
            r_next.status = r_reg.rx[0] ? `IMS_S_AW_NACK : `IMS_S_AW_ACK;
          end
        end
        ims_pkg::K_TX: r_next.status = r_reg.rx[0] ? `IMS_S_TX_NACK : `IMS_S_TX_ACK;
        default: begin
          r_next.data   = r_reg.rx[8:1];
          r_next.status = r_reg.rx[0] ? `IMS_S_RX_NACK : `IMS_S_RX_ACK;
        end
      endcase
    end

    // Disabling the interface drops the sequence and frees both wires
    if (!r_next.en) begin
      r_next.st      = ims_pkg::S_IDLE;
      r_next.scl_low = 1'b0;
      r_next.sda_low = 1'b0;
      r_next.owner   = 1'b0;
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      r_reg         <= '0;
      r_reg.st      <= ims_pkg::S_IDLE;
      r_reg.kind    <= ims_pkg::K_ADDR;
      r_reg.status  <= `IMS_STATUS_RST;
      r_reg.scl_q   <= `IMS_PIN_RST;
      r_reg.sda_q   <= `IMS_PIN_RST;
      r_reg.aw_rdy  <= 1'b1;
      r_reg.w_rdy   <= 1'b1;
      r_reg.ar_rdy  <= 1'b1;
      r_reg.pin_lvl <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // =====================================================================
  // Outputs
  assign S_AXI_AWREADY = r_reg.aw_rdy;
  assign S_AXI_WREADY  = r_reg.w_rdy;
  assign S_AXI_BRESP   = r_reg.bresp;
  assign S_AXI_BVALID  = r_reg.bvalid;
  assign S_AXI_ARREADY = r_reg.ar_rdy;
  assign S_AXI_RDATA   = {24'h000000, r_reg.rdata};
  assign S_AXI_RRESP   = r_reg.rresp;
  assign S_AXI_RVALID  = r_reg.rvalid;
  assign SCL_OUT       = r_reg.pin_lvl;
  assign SCL_OE        = r_reg.scl_low;
  assign SDA_OUT       = r_reg.pin_lvl;
  assign SDA_OE        = r_reg.sda_low;

  // =====================================================================
  // Checks
  a_hold_scl_low: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (r_reg.flag && r_reg.owner && r_reg.st == ims_pkg::S_HOLD) |-> SCL_OE)
    else $error("Bus clock released while step done flag is set");

  a_stop_self_clr: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (r_reg.st == ims_pkg::S_STOP && r_reg.ph == 2'h3 && adv) |=> (!r_reg.stop_request_bit && !SDA_OE && !SCL_OE))
    else $error("Stop request not cleared after STOP");

  a_stop_then_go: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (r_reg.st == ims_pkg::S_STOP && r_reg.ph == 2'h3 && adv && r_reg.sts && r_reg.en)
    |=> r_reg.st == ims_pkg::S_WAIT_FREE ##[1:20] r_reg.st == ims_pkg::S_START)
    else $error("No START after STOP with start request");

  a_start_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (r_reg.st == ims_pkg::S_START && !r_reg.rep && r_reg.ph == 2'h3 && adv && r_reg.en)
    |=> (r_reg.flag && r_reg.status == `IMS_S_START))
    else $error("START did not report 0x08");

  a_rep_start_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (r_reg.st == ims_pkg::S_START && r_reg.rep && r_reg.ph == 2'h3 && adv && r_reg.en)
    |=> (r_reg.flag && r_reg.owner && r_reg.status == `IMS_S_REP))
    else $error("Repeated START did not report 0x10");

  a_arb_release: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (arb_lost && r_reg.en) |=> (r_reg.status == `IMS_S_ARB && !SCL_OE && !SDA_OE)[*2])
    else $error("Arbitration loss did not release the bus with 0x38");

  a_tx_nack_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (finish && r_reg.kind == ims_pkg::K_TX && r_reg.en)
    |=> r_reg.status == ($past(r_reg.rx[0]) ? `IMS_S_TX_NACK : `IMS_S_TX_ACK))
    else $error("Wrong status after data byte sent");

  a_rx_data_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (finish && r_reg.kind == ims_pkg::K_RX && r_reg.en) |=> (r_reg.flag && r_reg.data == $past(r_reg.rx[8:1])))
    else $error("Received byte not in data register at flag set");

  a_rx_ack_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (finish && r_reg.kind == ims_pkg::K_RX && r_reg.en)
    |=> r_reg.status == ($past(r_reg.tx[8], 1) ? `IMS_S_RX_NACK : `IMS_S_RX_ACK))
    else $error("Receive status does not match acknowledge sent");

  a_collision_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    data_wr_nf |=> (r_reg.wc && $stable(r_reg.data)))
    else $error("Data write with flag low was not discarded");

endmodule : ims_master_seq

// >>> verilog/ims_map.svh
// Register offsets, field positions, status codes, reset values and timing of the two-wire master sequencer
`ifndef IMS_MAP_SVH
`define IMS_MAP_SVH

// =====================================================================
// Register map
`define IMS_ADDR_W      4
`define IMS_OFS_CTRL    4'h0
`define IMS_OFS_STATUS  4'h4
`define IMS_OFS_DATA    4'h8

// =====================================================================
// Control register fields
`define IMS_B_FLAG      7
`define IMS_B_ACK       6
`define IMS_B_STA       5
`define IMS_B_STO       4
`define IMS_B_WC        3
`define IMS_B_EN        2

// =====================================================================
// Status codes, low three bits always read as zero
`define IMS_S_START     8'h08
`define IMS_S_REP       8'h10
`define IMS_S_AW_ACK    8'h18
`define IMS_S_AW_NACK   8'h20
`define IMS_S_TX_ACK    8'h28
`define IMS_S_TX_NACK   8'h30
`define IMS_S_ARB       8'h38
`define IMS_S_AR_ACK    8'h40
`define IMS_S_AR_NACK   8'h48
`define IMS_S_RX_ACK    8'h50
`define IMS_S_RX_NACK   8'h58
`define IMS_S_IDLE      8'hf8

// =====================================================================
// Reset values and bus responses
`define IMS_STATUS_RST  8'hf8
`define IMS_PIN_RST     1'b1
`define IMS_RESP_OK     2'h0
`define IMS_RESP_ERR    2'h2

// =====================================================================
// Timing: quarter of a bus bit period
`define IMS_CLK_NS      25
`define IMS_QTR_NS      2500
`define IMS_QTR_CYC     ((`IMS_QTR_NS) / (`IMS_CLK_NS))

`endif

// >>> verilog/ims_pkg.sv
// Types shared by the two-wire master sequencer modules
`include "ims_map.svh"

package ims_pkg;

  typedef enum logic [2:0] {S_IDLE, S_WAIT_FREE, S_START, S_BIT, S_STOP, S_HOLD} ims_state_e;
  typedef enum logic [1:0] {K_ADDR, K_TX, K_RX} ims_kind_e;

  typedef struct packed {
    logic s1;
    logic s2;
  } ims_sync_s;

  typedef struct packed {
    ims_state_e             st;
    logic [1:0]             ph;
    logic [7:0]             cnt;
    logic [3:0]             bitn;
    logic [8:0]             tx;
    logic [8:0]             chk;
    logic [8:0]             rx;
    ims_kind_e              kind;
    logic                   rd;
    logic                   rep;
    logic                   sts;
    logic                   scl_low;
    logic                   sda_low;
    logic                   owner;
    logic                   busy;
    logic                   scl_q;
    logic                   sda_q;
    logic                   flag;
    logic                   ea;
    logic                   start_request_bit;
    logic                   stop_request_bit;
    logic                   wc;
    logic                   en;
    logic [7:0]             status;
    logic [7:0]             data;
    logic                   aw_ok;
    logic [`IMS_ADDR_W-1:0] aw_addr;
    logic                   w_ok;
    logic [7:0]             w_data;
    logic                   w_strb;
    logic                   aw_rdy;
    logic                   w_rdy;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   ar_rdy;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [7:0]             rdata;
    logic                   pin_lvl;
  } ims_top_s;

endpackage : ims_pkg

// >>> verilog/ims_sync.sv
// Two-flop synchroniser for a bus pin
`timescale 1ns/1ps
`include "ims_map.svh"

module ims_sync (
  input  wire logic clk,  // System clock
  input  wire logic rst,  // Synchronous reset, active high
  input  wire logic d,    // Asynchronous pin level
  output logic      q     // Synchronised level
);

  ims_pkg::ims_sync_s r_reg;
  ims_pkg::ims_sync_s r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg.s1 <= `IMS_PIN_RST;
      r_reg.s2 <= `IMS_PIN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;

endmodule : ims_sync

// >>> dv/ims_slave_model.sv
// Behavioural bus slave that acks addresses and returns a fixed byte
`timescale 1ns/1ps

module ims_slave_model #(
  parameter logic [7:0] TX_BYTE = 8'ha5  // Byte sent on every read
) (
  input  wire logic scl,     // Bus clock wire level
  input  wire logic sda,     // Bus data wire level
  output logic      sda_low  // Pulls data low when high
);
  int         n   = -1;
  logic       adr = 0;
  logic       rd  = 0;
  logic [7:0] sh  = 8'h00;
  initial sda_low = 0;
  // ===================================
  // Start and stop detection
  always @(negedge sda) if (scl) begin n = 0; adr = 1; rd = 0; end
  always @(posedge sda) if (scl) begin n = -1; sda_low = 0; end
  // ===================================
  // Bit shifting, master NACK ends a read
  always @(posedge scl) if (n >= 0) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8 && !adr && sda) rd = 0;
    n = n + 1;
  end
  always @(negedge scl) begin
    if (n == 8) begin sda_low = adr; if (adr) rd = sh[0]; end
    else if (n == 9) begin n = 0; adr = 0; sda_low = rd & ~TX_BYTE[7]; end
    else if (rd && !adr && n > 0) sda_low = ~TX_BYTE[7 - n];
  end
endmodule : ims_slave_model

// >>> dv/tb_ims_master_seq.sv
// Register-level testbench of the two-wire master sequencer
`timescale 1ns/1ps
`include "ims_map.svh"

module tb_ims_master_seq;
  logic        clk = 0, rst = 1;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, sda_low, scl_out, sda_out;
  logic        arb_pull = 0;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, q;
  int          err_count = 0, tests_run = 0, cyc = 0;
  wire         scl_w = !scl_oe;
  wire         sda_w = !(sda_oe | sda_low | arb_pull);

  always #12.5 clk = ~clk;

  ims_master_seq u_ims_master_seq (.CLOCK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SCL_IN(scl_w), .SCL_OUT(scl_out),
    .SCL_OE(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe));
  ims_slave_model u_ims_slave_model (.scl(scl_w), .sda(sda_w), .sda_low(sda_low));

  // ===================================
  // Checking and closing
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin err_count++; $display("mismatch at %0t: got %h want %h", $time, s, e); end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin err_count++; stop_test; end
  end

  // ===================================
  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ad, wd, b;
    ad = 0; wd = 0; b = 0;
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!b) begin
      @(negedge clk); ad |= awready; wd |= wready; b = bvalid; rs = bresp;
      @(posedge clk); awvalid <= !ad; wvalid <= !wd;
    end
    bready <= 0;
    chk({30'h0, rs}, {30'h0, `IMS_RESP_OK});
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    logic ar, r;
    ar = 0; r = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!r) begin
      @(negedge clk); ar |= arready; r = rvalid; q = rdata; rs = rresp;
      @(posedge clk); arvalid <= !ar;
    end
    rready <= 0;
    @(posedge clk);
  endtask : rd
  task automatic go(input logic [7:0] c, input logic [7:0] s);
    wr(`IMS_OFS_CTRL, c);
    do rd(`IMS_OFS_CTRL); while (q[7] !== 1'b1);
    rd(`IMS_OFS_STATUS);
    chk(q, {24'h0, s});
  endtask : go

  // ===================================
  // Master receive, repeated start and stop sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(4'hc); chk({30'h0, rs}, {30'h0, `IMS_RESP_ERR});
    rd(`IMS_OFS_STATUS); chk(q, {24'h0, `IMS_STATUS_RST});
    wr(`IMS_OFS_DATA, 8'h11); rd(`IMS_OFS_CTRL); chk(q & 32'h8, 32'h8);
    go(8'ha4, `IMS_S_START);
    wr(`IMS_OFS_DATA, 8'h55); go(8'h84, `IMS_S_AR_ACK);
    go(8'hc4, `IMS_S_RX_ACK); rd(`IMS_OFS_DATA); chk(q, 32'ha5);
    go(8'h84, `IMS_S_RX_NACK); rd(`IMS_OFS_DATA); chk(q, 32'ha5);
    wr(`IMS_OFS_CTRL, 8'h84); rd(`IMS_OFS_CTRL); chk(q & 32'h80, 32'h80);
    chk({31'h0, scl_w}, 0);
    go(8'ha4, `IMS_S_REP);
    wr(`IMS_OFS_DATA, 8'h54); go(8'h84, `IMS_S_AW_ACK);
    wr(`IMS_OFS_DATA, 8'h3c); go(8'h84, `IMS_S_TX_NACK);
    go(8'hb4, `IMS_S_START); rd(`IMS_OFS_CTRL); chk(q & 32'h10, 0);
    wr(`IMS_OFS_DATA, 8'h54); go(8'h84, `IMS_S_AW_ACK);
    wr(`IMS_OFS_CTRL, 8'h94);
    do rd(`IMS_OFS_STATUS); while (q !== {24'h0, `IMS_S_IDLE});
    rd(`IMS_OFS_CTRL); chk(q & 32'h10, 0);
    chk({30'h0, scl_w, sda_w}, 32'h3);
    go(8'ha4, `IMS_S_START);
    arb_pull <= 1;
    wr(`IMS_OFS_DATA, 8'hfe); go(8'h84, `IMS_S_ARB);
    chk({30'h0, scl_oe, sda_oe}, 0);
    arb_pull <= 0;
    repeat (4) @(posedge clk);
    chk({30'h0, scl_w, sda_w}, 32'h3);
    chk({30'h0, scl_out, sda_out}, 0);
    stop_test;
  end
endmodule : tb_ims_master_seq
